/* File: hdl/pin_router_pkg.sv */
// Types shared by the pin router
package pin_router_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_s;
endpackage

/* File: hdl/pin_router_regs.svh */
// Register offsets, field positions and reset values of the pin router
`ifndef PIN_ROUTER_REGS_SVH
`define PIN_ROUTER_REGS_SVH
`define ROUTE_CTRL_A_ADDR   8'hE1
`define ROUTE_CTRL_B_ADDR   8'hE2
`define PORT0_LATCH_ADDR    8'h80
`define PORT1_LATCH_ADDR    8'h90
`define PORT0_DRIVE_ADDR    8'hA4
`define PORT1_DRIVE_ADDR    8'hA5
`define PORT0_INSEL_ADDR    8'hF1
`define PORT1_INSEL_ADDR    8'hF2
`define ROUTE_A_MASK        8'hFD
`define ROUTE_B_MASK        8'h43
`define ROUTE_RESET         8'h00
`define LATCH_RESET         8'hFF
`define DRIVE_RESET         8'h00
`define INSEL_RESET         8'hFF
`define BIT_SERIAL          0
`define BIT_IRQ0            2
`define BIT_IRQ1            3
`define BIT_TMR0            4
`define BIT_TMR1            5
`define BIT_TMR2            6
`define BIT_TRIG            7
`define BIT_CMP0            0
`define BIT_CMP1            1
`define BIT_SYSCK           6
`define PIN_TX              0
`define PIN_RX              1
`define PIN_IRQ0            2
`define PIN_IRQ1            3
`define PIN_CMP0            2
`define PIN_CMP1            5
`define PIN_SYSCK           6
`define PIN_TMR0            4
`define PIN_TMR1            5
`define PIN_TMR2            6
`define PIN_TRIG            7
`endif

/* File: hdl/port_peripheral_pin_router.sv */
// Port pin router with drive, input mode and latch control for ports 0 and 1
`timescale 1ns/1ps
`include "pin_router_regs.svh"
module port_peripheral_pin_router (
  input  wire logic                    mclk_i,
  input  wire logic                    rst_i,
  input  wire pin_router_pkg::reg_req_s req_i,
  output logic [7:0]                   rdata_o,
  input  wire logic                    serial_tx_i,
  output logic                         serial_rx_o,
  input  wire logic                    cmp_zero_out_i,
  input  wire logic                    cmp_one_out_i,
  input  wire logic                    core_clock_i,
  output logic                         tmr_zero_in_o,
  output logic                         tmr_one_in_o,
  output logic                         tmr_two_in_o,
  output logic                         tmr_two_trig_in_o,
  output logic                         ext_irq_zero_n_o,
  output logic                         ext_irq_one_n_o,
  input  wire logic [7:0]              port0_pin_i,
  input  wire logic [7:0]              port1_pin_i,
  output pin_router_pkg::pin_drive_s   port0_o,
  output pin_router_pkg::pin_drive_s   port1_o
);
  logic [7:0] route_ctrl_a;
  logic [7:0] route_ctrl_b;
  logic [7:0] port0_latch;
  logic [7:0] port1_latch;
  logic [7:0] port_zero_drive_cfg;
  logic [7:0] port_one_drive_cfg;
  logic [7:0] port_zero_input_sel;
  logic [7:0] port_one_input_sel;
  logic [7:0] p0_meta;
  logic [7:0] p0_sync;
  logic [7:0] p1_meta;
  logic [7:0] p1_sync;
  logic [7:0] p0_in;
  logic [7:0] p1_in;
  logic [7:0] p0_val;
  logic [7:0] p1_val;
  logic [7:0] p0_sel;
  logic [7:0] p1_sel;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      route_ctrl_a <= `ROUTE_RESET;
      route_ctrl_b <= `ROUTE_RESET;
    end else if (req_i.wr) begin
      if (req_i.addr == `ROUTE_CTRL_A_ADDR) begin
        route_ctrl_a <= req_i.wdata & `ROUTE_A_MASK;
      end
      if (req_i.addr == `ROUTE_CTRL_B_ADDR) begin
        route_ctrl_b <= req_i.wdata & `ROUTE_B_MASK;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      port0_latch <= `LATCH_RESET;
      port1_latch <= `LATCH_RESET;
      port_zero_drive_cfg <= `DRIVE_RESET;
      port_one_drive_cfg  <= `DRIVE_RESET;
      port_zero_input_sel <= `INSEL_RESET;
      port_one_input_sel  <= `INSEL_RESET;
    end else if (req_i.wr) begin
      case (req_i.addr)
        `PORT0_LATCH_ADDR: port0_latch <= req_i.wdata;
        `PORT1_LATCH_ADDR: port1_latch <= req_i.wdata;
        `PORT0_DRIVE_ADDR: port_zero_drive_cfg <= req_i.wdata;
        `PORT1_DRIVE_ADDR: port_one_drive_cfg  <= req_i.wdata;
        `PORT0_INSEL_ADDR: port_zero_input_sel <= req_i.wdata;
        `PORT1_INSEL_ADDR: port_one_input_sel  <= req_i.wdata;
        default: ;
      endcase
    end
  end

  // Pin synchronisers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      p0_meta <= 8'hFF;
      p0_sync <= 8'hFF;
      p1_meta <= 8'hFF;
      p1_sync <= 8'hFF;
    end else begin
      p0_meta <= port0_pin_i;
      p0_sync <= p0_meta;
      p1_meta <= port1_pin_i;
      p1_sync <= p1_meta;
    end
  end

  // Analog-selected pins give no digital level
  assign p0_in = p0_sync & port_zero_input_sel;
  assign p1_in = p1_sync & port_one_input_sel;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (req_i.rd) begin
      case (req_i.addr)
        `ROUTE_CTRL_A_ADDR: rdata_o <= route_ctrl_a;
        `ROUTE_CTRL_B_ADDR: rdata_o <= route_ctrl_b;
        `PORT0_LATCH_ADDR:  rdata_o <= p0_in;
        `PORT1_LATCH_ADDR:  rdata_o <= p1_in;
        `PORT0_DRIVE_ADDR:  rdata_o <= port_zero_drive_cfg;
        `PORT1_DRIVE_ADDR:  rdata_o <= port_one_drive_cfg;
        `PORT0_INSEL_ADDR:  rdata_o <= port_zero_input_sel;
        `PORT1_INSEL_ADDR:  rdata_o <= port_one_input_sel;
        default:            rdata_o <= 8'h00;
      endcase
    end
  end

  // Peripheral output selection
  always_comb begin
    p0_sel = port0_latch;
    p1_sel = port1_latch;
    if (route_ctrl_a[`BIT_SERIAL]) begin
      p0_sel[`PIN_TX] = serial_tx_i;
    end
    if (route_ctrl_b[`BIT_CMP0]) begin
      p1_sel[`PIN_CMP0] = cmp_zero_out_i;
    end
    if (route_ctrl_b[`BIT_CMP1]) begin
      p1_sel[`PIN_CMP1] = cmp_one_out_i;
    end
  end

  // Registered pin values; the clock output is combinational by nature
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      p0_val <= `LATCH_RESET;
      p1_val <= `LATCH_RESET;
    end else begin
      p0_val <= p0_sel;
      p1_val <= p1_sel;
    end
  end

  always_comb begin
    port0_o.out = p0_val;
    port1_o.out = p1_val;
    if (route_ctrl_b[`BIT_SYSCK]) begin
      port1_o.out[`PIN_SYSCK] = core_clock_i;
    end
    // Open-drain drives only a low; push-pull drives always
    port0_o.oe = port_zero_drive_cfg | ~port0_o.out;
    port1_o.oe = port_one_drive_cfg | ~port1_o.out;
  end

  // Routed inputs; unrouted inputs rest inactive
  assign serial_rx_o = route_ctrl_a[`BIT_SERIAL] ? p0_in[`PIN_RX] : 1'b1;
  assign tmr_zero_in_o = route_ctrl_a[`BIT_TMR0] & p0_in[`PIN_TMR0];
  assign tmr_one_in_o = route_ctrl_a[`BIT_TMR1] & p0_in[`PIN_TMR1];
  assign tmr_two_in_o = route_ctrl_a[`BIT_TMR2] & p0_in[`PIN_TMR2];
  assign tmr_two_trig_in_o = route_ctrl_a[`BIT_TRIG] & p0_in[`PIN_TRIG];
  assign ext_irq_zero_n_o = route_ctrl_a[`BIT_IRQ0] ? p0_in[`PIN_IRQ0] : 1'b1;
  assign ext_irq_one_n_o = route_ctrl_a[`BIT_IRQ1] ? p0_in[`PIN_IRQ1] : 1'b1;

  property p_route_a_unused;
    @(posedge mclk_i) disable iff (rst_i) route_ctrl_a[1] == 1'b0;
  endproperty
  a_route_a_unused: assert property (p_route_a_unused) else $error("route a bit1 set");

  property p_route_b_unused;
    @(posedge mclk_i) disable iff (rst_i) (route_ctrl_b & 8'hBC) == 8'h00;
  endproperty
  a_route_b_unused: assert property (p_route_b_unused) else $error("route b unused set");

  property p_serial_tx;
    @(posedge mclk_i) disable iff (rst_i)
      route_ctrl_a[0] && $stable(route_ctrl_a) |=> port0_o.out[0] == $past(serial_tx_i);
  endproperty
  a_serial_tx: assert property (p_serial_tx) else $error("tx not routed");

  property p_sysck;
    @(posedge mclk_i) disable iff (rst_i)
      route_ctrl_b[6] |-> port1_o.out[6] == core_clock_i;
  endproperty
  a_sysck: assert property (p_sysck) else $error("clock not routed");

  property p_cmp1;
    @(posedge mclk_i) disable iff (rst_i)
      route_ctrl_b[1] && $stable(route_ctrl_b) |=> port1_o.out[5] == $past(cmp_one_out_i);
  endproperty
  a_cmp1: assert property (p_cmp1) else $error("cmp1 not routed");

  property p_cmp0;
    @(posedge mclk_i) disable iff (rst_i)
      !route_ctrl_b[0] && $stable(route_ctrl_b) |=> port1_o.out[2] == $past(port1_latch[2]);
  endproperty
  a_cmp0: assert property (p_cmp0) else $error("cmp0 leaks");

  property p_tmr0;
    @(posedge mclk_i) disable iff (rst_i)
      !route_ctrl_a[4] |-> !tmr_zero_in_o;
  endproperty
  a_tmr0: assert property (p_tmr0) else $error("timer0 unrouted active");

  property p_irq0;
    @(posedge mclk_i) disable iff (rst_i)
      !route_ctrl_a[2] |-> ext_irq_zero_n_o;
  endproperty
  a_irq0: assert property (p_irq0) else $error("irq0 unrouted active");

  property p_open_drain;
    @(posedge mclk_i) disable iff (rst_i)
      !port_zero_drive_cfg[3] && port0_o.out[3] |-> !port0_o.oe[3];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain drives high");

  property p_reset_state;
    @(posedge mclk_i) $fell(rst_i) |-> port0_latch == 8'hFF && port_zero_drive_cfg == 8'h00
      && port0_o.oe == 8'h00;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset pins not floating");
endmodule

/* File: tb/pin_board_model.sv */
// Board circuitry on one port: pull-ups plus optional external sources
`timescale 1ns/1ps
module pin_board_model (
  input  wire pin_router_pkg::pin_drive_s port_i,
  input  wire logic [7:0]                 ext_en_i,
  input  wire logic [7:0]                 ext_val_i,
  output logic [7:0]                      pin_o
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (port_i.oe[i] && ext_en_i[i])
        pin_o[i] = 1'bx;
      else if (port_i.oe[i])
        pin_o[i] = port_i.out[i];
      else if (ext_en_i[i])
        pin_o[i] = ext_val_i[i];
      else
        pin_o[i] = 1'b1;
    end
  end
endmodule

/* File: tb/port_peripheral_pin_router_test.sv */
// Self-checking bench of the port pin router
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module port_peripheral_pin_router_test;
  logic                       mclk_i = 1'b0;
  logic                       rst_i = 1'b1;
  pin_router_pkg::reg_req_s   req_i = '0;
  pin_router_pkg::pin_drive_s port0_o, port1_o;
  logic [7:0]                 rdata_o, p0_pin, p1_pin, a, b, c1, l1, xp0, xo1;
  logic [7:0]                 ext_en = '0, ext_val = '0;
  logic                       tx = 1'b0, c0 = 1'b0, cm1 = 1'b0, ck = 1'b0;
  logic                       rx, t0, t1, t2, tt, q0, q1, x0;
  logic [31:0]                r;
  int                         miscompares = 0, n_checks = 0, cycles = 0;

  always #2.5 mclk_i = ~mclk_i;

  port_peripheral_pin_router u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i),
    .rdata_o(rdata_o), .serial_tx_i(tx), .serial_rx_o(rx), .cmp_zero_out_i(c0),
    .cmp_one_out_i(cm1), .core_clock_i(ck), .tmr_zero_in_o(t0), .tmr_one_in_o(t1),
    .tmr_two_in_o(t2), .tmr_two_trig_in_o(tt), .ext_irq_zero_n_o(q0),
    .ext_irq_one_n_o(q1), .port0_pin_i(p0_pin), .port1_pin_i(p1_pin),
    .port0_o(port0_o), .port1_o(port1_o));
  pin_board_model u_b0 (.port_i(port0_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .pin_o(p0_pin));
  pin_board_model u_b1 (.port_i(port1_o), .ext_en_i(8'h00), .ext_val_i(8'h00),
    .pin_o(p1_pin));

  task automatic end_of_test();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge mclk_i);
    req_i <= {1'b1, 1'b0, ad, d};
    @(posedge mclk_i);
    req_i <= '0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge mclk_i);
    req_i <= {1'b0, 1'b1, ad, 8'h00};
    @(posedge mclk_i);
    req_i <= '0;
    #1;
    `CHK(rdata_o, e)
  endtask

  // Port 1 output: latch with routed peripherals overlaid
  function automatic logic [7:0] exp_out1();
    exp_out1 = l1;
    if (b[0]) exp_out1[2] = c0;
    if (b[1]) exp_out1[5] = cm1;
    if (b[6]) exp_out1[6] = ck;
  endfunction

  // Port 0 pin levels: board source or pull-up, pin 0 from the device
  function automatic logic [7:0] exp_pin0();
    exp_pin0 = ((ext_val | ~ext_en) & 8'hFE) | {7'h00, x0};
  endfunction

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    r = $urandom(32'hB5952456);
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    `CHK(port0_o, 16'hFF00)
    `CHK(port1_o, 16'hFF00)
    rd(8'hE1, 8'h00);
    rd(8'hF1, 8'hFF);
    rd(8'h80, 8'hFF);
    wr(8'hE1, 8'hFF);
    rd(8'hE1, 8'hFD);
    wr(8'hE2, 8'hFF);
    rd(8'hE2, 8'h43);
    wr(8'h3C, 8'h5A);
    rd(8'h3C, 8'h00);
    wr(8'h80, 8'hFF);
    wr(8'hA4, 8'h00);
    rd(8'hA4, 8'h00);
    wr(8'hF1, 8'hFF);
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      a = (i < 2) ? {8{i[0]}} & 8'hFD : r[7:0] & 8'hFD;
      b = (i < 2) ? {8{i[0]}} & 8'h43 : r[15:8] & 8'h43;
      c1 = r[23:16];
      l1 = r[31:24];
      wr(8'hE1, a);
      wr(8'hE2, b);
      wr(8'hA5, c1);
      wr(8'h90, l1);
      r = $urandom;
      {tx, c0, cm1, ck} <= r[3:0];
      ext_val <= r[15:8];
      ext_en <= r[23:16] & 8'hFE;
      repeat (4) @(posedge mclk_i);
      #1;
      x0 = ~a[0] | tx;
      xp0 = exp_pin0();
      xo1 = exp_out1();
      `CHK(port0_o, {7'h7F, x0, 7'h00, ~x0})
      `CHK(port1_o, {xo1, c1 | ~xo1})
      `CHK({rx, q1, q0}, {~a[0] | xp0[1], ~a[3] | xp0[3], ~a[2] | xp0[2]})
      `CHK({tt, t2, t1, t0}, a[7:4] & xp0[7:4])
      rd(8'h80, xp0);
      rd(8'h90, xo1);
      rd(8'hA5, c1);
    end
    wr(8'hF1, 8'h0F);
    wr(8'hF2, 8'hF0);
    rd(8'h80, xp0 & 8'h0F);
    rd(8'h90, xo1 & 8'hF0);
    rd(8'hF2, 8'hF0);
    // Mid-run reset, then reset values checked and read back
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    `CHK(port0_o, 16'hFF00)
    `CHK(port1_o, 16'hFF00)
    rd(8'hE2, 8'h00);
    rd(8'hF2, 8'hFF);
    rd(8'h80, ext_val | ~ext_en);
    end_of_test();
  end
endmodule
